// ===== shared/imvp_pkg.sv
// Constants and tables for the interrupt priority and vector block
package imvp_pkg;
  // Source counts and indices, default order, index 0 highest
  localparam int N_SRC = 37;
  localparam int N_PER = 29;
  localparam int N_VREG = 17;
  localparam int N_PFLD = 9;
  localparam int SRC_NMI = 0;
  localparam int SRC_UBRK = 1;
  localparam int SRC_DBG = 2;
  localparam int SRC_LINE0 = 3;
  localparam int SRC_ENC = 7;
  localparam int SRC_PER0 = 8;
  localparam int PER_ETHER = 4;
  // Fixed vectors and levels
  localparam logic [6:0] VEC_NMI = 7'h0B;
  localparam logic [6:0] VEC_UBRK = 7'h0C;
  localparam logic [6:0] VEC_DBG = 7'h0D;
  localparam logic [6:0] VEC_LINE0 = 7'h40;
  localparam logic [6:0] VEC_ENC_BASE = 7'h40;
  localparam logic [6:0] VEC_MAX = 7'h7F;
  localparam logic [4:0] LVL_NMI = 5'h10;
  localparam logic [4:0] LVL_BRK = 5'h0F;
  // Vector register field positions
  localparam int VF_HI_LSB = 8;
  localparam int VF_LO_LSB = 0;
  localparam int VF_W = 7;
  // Priority field positions
  localparam int PF_W = 4;
  localparam int PF_DMA_LSB = 8;
  localparam int PF_WDT_LSB = 4;
  localparam int PF_HI_LSB = 12;
  localparam int PF_MID_LSB = 8;
  localparam int PF_LOW_LSB = 4;
  localparam int PF_BOT_LSB = 0;
  // Ethernet DMA status sources
  localparam int ETH_N = 19;
  localparam int MAC_N = 3;
  localparam int ETH_MERGE_POS = 0;
  // Reset values
  localparam logic [31:0] RST_ADDR = 32'h0000_0000;
  localparam logic [6:0] RST_VEC = 7'h00;
  localparam logic [4:0] RST_LVL = 5'h00;
  localparam logic [5:0] RST_SRC = 6'h00;
  // Per peripheral: {vector register index, 1 = bits 14..8}
  localparam logic [5:0] PV_MAP [N_PER] = '{
    6'h00, 6'h02, 6'h05, 6'h04, 6'h07, 6'h09, 6'h08, 6'h0B,
    6'h0D, 6'h0C, 6'h0F, 6'h0E, 6'h11, 6'h13, 6'h12, 6'h15,
    6'h14, 6'h17, 6'h16, 6'h19, 6'h18, 6'h1B, 6'h1A, 6'h1D,
    6'h1C, 6'h1F, 6'h1E, 6'h21, 6'h20};
  // Per peripheral: priority field index
  localparam logic [3:0] PV_PF [N_PER] = '{
    4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h3, 4'h3, 4'h3,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h5, 4'h5, 4'h5,
    4'h5, 4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h7,
    4'h7, 4'h8, 4'h8, 4'h8, 4'h8};
endpackage : imvp_pkg

// ===== design/imvp_arb.sv
// Highest level wins, ties go to the lowest source index
`timescale 1ns/10ps
module imvp_arb (
  input wire logic [4:0] lvl_in [imvp_pkg::N_SRC], // Level per source
  output logic valid_out,                          // Some level nonzero
  output logic [5:0] idx_out,                      // Winning source
  output logic [4:0] lvl_out                       // Winning level
);
  import imvp_pkg::*;

  // Strict greater keeps the earlier index on equal levels
  always_comb begin
    valid_out = 1'b0;
    idx_out = RST_SRC;
    lvl_out = RST_LVL;
    for (int i = 0; i < N_SRC; i++) begin
      if (lvl_in[i] > lvl_out) begin
        valid_out = 1'b1;
        idx_out = 6'(i);
        lvl_out = lvl_in[i];
      end
    end
  end
endmodule : imvp_arb

// ===== design/imvp_top.sv
// Interrupt priority and vector selection toward the processor core
`timescale 1ns/10ps
// Summary of operation
// [R1] External fetch supplies vector, must be 0..127
// [R2] Peripheral vectors from 7-bit register fields
// [R3] Mode bit picks encoded level or lines
// [R4] Reserved second vector slot never accessed
// [R5] Ethernet request ORs 19 permitted status bits
// [R6] Three MAC bits merge into one status bit
// [R7] Fixed vectors 11,12,13 and lines 64..67
// [R8] Refresh shares watchdog level, ranks below it
// [R9] Each line level from own field, 0 masks
// [R10] Equal levels resolved by fixed default order
module imvp_top (
  input wire logic mclk_in,                       // 200 MHz clock
  input wire logic rst_in,                        // Async reset, high
  input wire logic nmi_in,                        // Non-maskable request
  input wire logic user_break_in,                 // User break request
  input wire logic debug_port_request_in,         // Debug port request
  input wire logic [3:0] ext_pins_n_in,           // External pins, low
  input wire logic ext_pin_mode_sel_in,           // 1 = encoded level
  input wire logic ext_vec_fetch_in,              // Pins fetch vector
  input wire logic [7:0] ext_vec_in,              // Fetched vector
  input wire logic [1:0] dma_req_in,              // DMA channel ends
  input wire logic wdt_interval_in,               // Watchdog interval
  input wire logic refresh_compare_request_in,    // Refresh match
  input wire logic [2:0] frt_req_in,              // Timer capture/cmp/ovf
  input wire logic [12:0] pulse_req_in,           // Pulse unit requests
  input wire logic [7:0] serial_req_in,           // Serial FIFO requests
  input wire logic [imvp_pkg::ETH_N-1:0] ether_dma_status_reg_in, // Status
  input wire logic [imvp_pkg::ETH_N-1:0] ether_dma_permit_reg_in, // Permit
  input wire logic [imvp_pkg::MAC_N-1:0] mac_status_reg_in,   // MAC status
  input wire logic [imvp_pkg::MAC_N-1:0] mac_copy_enable_in,  // Copy bits
  input wire logic [15:0] dma_wdt_priority_reg_in,  // DMA, watchdog
  input wire logic [15:0] ether_frt_priority_reg_in, // Ethernet, timer
  input wire logic [15:0] pin_priority_reg_in,    // Four line levels
  input wire logic [15:0] pulse_serial_priority_reg_in, // Pulse, serial 1
  input wire logic [15:0] serial2_priority_reg_in, // Serial 2
  input wire logic [15:0] vector_regs_in [imvp_pkg::N_VREG], // Vectors
  input wire logic [31:0] vector_base_reg_in,     // Table base
  output logic irq_req_out,                       // Request to core
  output logic [4:0] irq_level_out,               // Winning level
  output logic [6:0] irq_vector_out,              // Winning vector
  output logic [31:0] vec_table_addr_out,         // Base + 4*vector
  output logic [5:0] irq_src_out,                 // Winning source
  output logic encoded_mode_out,                  // Encoded mode active
  output logic ext_vec_range_err_out,             // Fetched vector > 127
  output logic ether_dma_request_out              // Combined Ethernet
);
  import imvp_pkg::*;

  // Seven-bit vector field from a vector register
  function automatic logic [6:0] vfield(input logic [15:0] r,
                                        input logic hi);
    vfield = hi ? r[VF_HI_LSB +: VF_W] : r[VF_LO_LSB +: VF_W];
  endfunction : vfield

  logic [3:0] pin_s1;
  logic [3:0] pin_s2;
  logic [3:0] pin_s3;
  logic [3:0] pin_f;
  logic [ETH_N-1:0] eth_eff;
  logic ether_dma_request;
  logic [3:0] pfld [N_PFLD];
  logic [4:0] lvl [N_SRC];
  logic [6:0] vec [N_SRC];
  logic [N_PER-1:0] per_req;
  logic [6:0] ext_vec_q;
  logic ext_vec_bad;
  logic win_valid;
  logic [5:0] win_idx;
  logic [4:0] win_lvl;
  logic [6:0] next_vec;

  // Three stage pin sampling, only stage two and three are compared
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_s1 <= 4'hF;
      pin_s2 <= 4'hF;
      pin_s3 <= 4'hF;
      pin_f <= 4'hF;
    end else begin
      pin_s1 <= ext_pins_n_in;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_f <= (pin_s2 & pin_s3) | (pin_f & (pin_s2 | pin_s3));
    end
  end

  // Merge bit also carries the enabled MAC status bits
  always_comb begin
    eth_eff = ether_dma_status_reg_in;
    eth_eff[ETH_MERGE_POS] = ether_dma_status_reg_in[ETH_MERGE_POS] |
                             (|(mac_status_reg_in & mac_copy_enable_in)); // [R6]
  end

  // Registered so the status fan-in does not reach the arbiter
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ether_dma_request <= 1'b0;
    end else begin
      ether_dma_request <= |(eth_eff & ether_dma_permit_reg_in); // [R5]
    end
  end

  // Priority fields shared by groups of peripheral sources
  assign pfld[0] = dma_wdt_priority_reg_in[PF_DMA_LSB +: PF_W];
  assign pfld[1] = dma_wdt_priority_reg_in[PF_WDT_LSB +: PF_W]; // [R8]
  assign pfld[2] = ether_frt_priority_reg_in[PF_HI_LSB +: PF_W];
  assign pfld[3] = ether_frt_priority_reg_in[PF_MID_LSB +: PF_W];
  assign pfld[4] = pulse_serial_priority_reg_in[PF_HI_LSB +: PF_W];
  assign pfld[5] = pulse_serial_priority_reg_in[PF_MID_LSB +: PF_W];
  assign pfld[6] = pulse_serial_priority_reg_in[PF_LOW_LSB +: PF_W];
  assign pfld[7] = pulse_serial_priority_reg_in[PF_BOT_LSB +: PF_W];
  assign pfld[8] = serial2_priority_reg_in[PF_HI_LSB +: PF_W];

  // Peripheral requests in default order, watchdog before refresh
  assign per_req = {serial_req_in, pulse_req_in, frt_req_in,
                    ether_dma_request, refresh_compare_request_in,
                    wdt_interval_in, dma_req_in}; // [R8] [R10]

  // Fixed sources
  assign lvl[SRC_NMI] = nmi_in ? LVL_NMI : RST_LVL;
  assign vec[SRC_NMI] = VEC_NMI; // [R7]
  assign lvl[SRC_UBRK] = user_break_in ? LVL_BRK : RST_LVL;
  assign vec[SRC_UBRK] = VEC_UBRK; // [R7]
  assign lvl[SRC_DBG] = debug_port_request_in ? LVL_BRK : RST_LVL;
  assign vec[SRC_DBG] = VEC_DBG; // [R7]

  // Independent lines, only in line mode; level 0 masks a line
  for (genvar i = 0; i < 4; i++) begin : g_line
    logic [3:0] fld;
    assign fld = pin_priority_reg_in[PF_HI_LSB - 4 * i +: PF_W]; // [R9]
    assign lvl[SRC_LINE0 + i] = (!ext_pin_mode_sel_in && !pin_f[i]) ?
                                {1'b0, fld} : RST_LVL; // [R3] [R9]
    assign vec[SRC_LINE0 + i] = ext_vec_fetch_in ? ext_vec_q :
                                VEC_LINE0 + 7'(i); // [R1] [R7]
  end

  // Encoded level source, pins give level 1..15 in encoded mode
  assign lvl[SRC_ENC] = ext_pin_mode_sel_in ? {1'b0, ~pin_f} : RST_LVL; // [R3]
  assign vec[SRC_ENC] = ext_vec_fetch_in ? ext_vec_q :
                        VEC_ENC_BASE + {3'h0, ~pin_f}; // [R1]

  // Peripheral sources; the reserved slot has no port, never touched
  for (genvar p = 0; p < N_PER; p++) begin : g_per
    assign lvl[SRC_PER0 + p] = per_req[p] ?
                               {1'b0, pfld[PV_PF[p]]} : RST_LVL;
    assign vec[SRC_PER0 + p] = vfield(vector_regs_in[PV_MAP[p][5:1]],
                                      PV_MAP[p][0]); // [R2] [R4]
  end

  // Fetched vector sampled; top bit set means out of range
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ext_vec_q <= RST_VEC;
      ext_vec_bad <= 1'b0;
    end else begin
      ext_vec_q <= ext_vec_in[7] ? VEC_MAX : ext_vec_in[6:0]; // [R1]
      ext_vec_bad <= ext_vec_in[7]; // [R1]
    end
  end

  imvp_arb u_arb (
    .lvl_in(lvl),
    .valid_out(win_valid),
    .idx_out(win_idx),
    .lvl_out(win_lvl)
  );

  assign next_vec = vec[win_idx];

  // Winner presented to the core one cycle after arbitration
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_req_out <= 1'b0;
      irq_level_out <= RST_LVL;
      irq_vector_out <= RST_VEC;
      vec_table_addr_out <= RST_ADDR;
      irq_src_out <= RST_SRC;
    end else begin
      irq_req_out <= win_valid; // [R10]
      irq_level_out <= win_lvl;
      irq_vector_out <= win_valid ? next_vec : RST_VEC;
      vec_table_addr_out <= win_valid ?
        vector_base_reg_in + {23'h0, next_vec, 2'h0} : RST_ADDR; // [R7]
      irq_src_out <= win_idx;
    end
  end

  // Status outputs
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      encoded_mode_out <= 1'b0;
      ext_vec_range_err_out <= 1'b0;
      ether_dma_request_out <= 1'b0;
    end else begin
      encoded_mode_out <= ext_pin_mode_sel_in; // [R3]
      ext_vec_range_err_out <= ext_vec_bad && ext_vec_fetch_in; // [R1]
      ether_dma_request_out <= ether_dma_request;
    end
  end
endmodule : imvp_top

// ===== verif/imvp_core_model.sv
// Behavioural core that accepts the block's winning request
`timescale 1ns/10ps
module imvp_core_model (
  input wire logic clk_in, // Core clock
  input wire logic rst_in, // Async reset, high
  input wire logic req_in, // Request from block
  input wire logic [6:0] vec_in, // Offered vector
  output logic taken_out, // Request seen last edge
  output logic [6:0] vec_out // Vector taken
);
  // Seven bits only, so a vector above 127 cannot be taken
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      taken_out <= 1'b0;
      vec_out <= 7'h00;
    end else begin
      taken_out <= req_in;
      vec_out <= req_in ? vec_in : vec_out;
    end
  end
endmodule : imvp_core_model

// ===== verif/imvp_top_properties.sv
// Concurrent checks on the priority and vector outputs
`timescale 1ns/10ps
module imvp_top_chk (
  input wire logic mclk_in, // Clock
  input wire logic rst_in, // Reset
  input wire logic nmi_in, // Non-maskable
  input wire logic user_break_in, // Break
  input wire logic ext_pin_mode_sel_in, // Pin mode
  input wire logic ext_vec_fetch_in, // Fetch mode
  input wire logic [7:0] ext_vec_in, // Fetched vector
  input wire logic wdt_interval_in, // Watchdog
  input wire logic refresh_compare_request_in, // Refresh
  input wire logic [18:0] ether_dma_status_reg_in, // Status
  input wire logic [18:0] ether_dma_permit_reg_in, // Permit
  input wire logic [2:0] mac_status_reg_in, // MAC status
  input wire logic [2:0] mac_copy_enable_in, // MAC copy
  input wire logic [15:0] vector_regs_in [imvp_pkg::N_VREG], // Vectors
  input wire logic [31:0] vector_base_reg_in, // Base
  input wire logic irq_req_out, // Request
  input wire logic [4:0] irq_level_out, // Level
  input wire logic [6:0] irq_vector_out, // Vector
  input wire logic [31:0] vec_table_addr_out, // Address
  input wire logic [5:0] irq_src_out, // Source
  input wire logic ext_vec_range_err_out, // Range flag
  input wire logic ether_dma_request_out // Ethernet
);
  import imvp_pkg::*;
  logic eth_any;
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // Merged MAC bits land in status bit 0 before the permit mask
  assign eth_any = |({ether_dma_status_reg_in[18:1],
    ether_dma_status_reg_in[0] | |(mac_status_reg_in & mac_copy_enable_in)}
    & ether_dma_permit_reg_in);
  a_nmi_fixed: assert property (nmi_in |=> irq_req_out &&
    irq_level_out == 5'h10 && irq_vector_out == 7'h0B && irq_src_out == 6'h00)
    else $error("nmi not presented with its fixed vector");
  a_brk_vector: assert property (user_break_in && !nmi_in |=>
    irq_level_out == 5'h0F && irq_vector_out == 7'h0C)
    else $error("break request vector or level wrong");
  a_table_addr: assert property (irq_req_out |-> vec_table_addr_out ==
    $past(vector_base_reg_in) + {23'h000000, irq_vector_out, 2'b00})
    else $error("table address not base plus four times vector");
  a_fetch_range: assert property ((ext_vec_fetch_in &&
    ext_vec_in[7]) [*2] |=> ext_vec_range_err_out)
    else $error("fetched vector above 127 not flagged");
  a_wdt_ranks: assert property (wdt_interval_in &&
    refresh_compare_request_in |=> irq_src_out != 6'h0B)
    else $error("refresh won over watchdog interval");
  a_refresh_vec: assert property (irq_req_out && irq_src_out == 6'h0B
    |-> irq_vector_out == $past(vector_regs_in[2][6:0]))
    else $error("refresh vector not from low field");
  a_mode_lines: assert property (ext_pin_mode_sel_in [*2] |=>
    !(irq_req_out && irq_src_out inside {[6'h03:6'h06]}))
    else $error("request line won in encoded mode");
  a_ether_or: assert property (!$past(rst_in) && !$past(rst_in, 2)
    |-> ether_dma_request_out == $past(eth_any, 2))
    else $error("ethernet request not the permitted status or");
endmodule : imvp_top_chk
bind imvp_top imvp_top_chk imvp_top_chk_inst (.*);

// ===== verif/imvp_top_tb.sv
// Self-checking bench for the priority and vector block
`timescale 1ns/10ps
module imvp_top_tb;
  import imvp_pkg::*;
  logic clk = 1'b0, rst = 1'b1, nmi = 1'b0, ubrk = 1'b0, dbg = 1'b0;
  logic mode = 1'b0, fetch = 1'b0, wdt = 1'b0, refr = 1'b0;
  logic [3:0] pins_n = 4'hF;
  logic [7:0] xvec = 8'h00;
  logic [1:0] dma = 2'h0;
  logic [2:0] frt = 3'h0, mac = 3'h0, cp = 3'h0;
  logic [18:0] st = 19'h00000, pm = 19'h00000;
  logic [15:0] p_dw = 16'h0000, p_ef = 16'h0000, p_pin = 16'h0000;
  logic [15:0] vregs [N_VREG];
  logic [31:0] base = 32'h0000_1000;
  logic req, err, eth, encm, taken;
  logic [4:0] lvl;
  logic [6:0] vec, cvec;
  logic [31:0] addr;
  int failures = 0, checks_done = 0;
  // Half period of 2.5 ns gives 200 MHz
  initial forever #2.5 clk = ~clk;
  // Pulse, serial and their priority inputs stay idle
  imvp_top imvp_top_inst (.mclk_in(clk), .rst_in(rst), .nmi_in(nmi),
    .user_break_in(ubrk), .debug_port_request_in(dbg),
    .ext_pins_n_in(pins_n), .ext_pin_mode_sel_in(mode),
    .ext_vec_fetch_in(fetch), .ext_vec_in(xvec), .dma_req_in(dma),
    .wdt_interval_in(wdt), .refresh_compare_request_in(refr),
    .frt_req_in(frt), .pulse_req_in(13'h0000), .serial_req_in(8'h00),
    .ether_dma_status_reg_in(st), .ether_dma_permit_reg_in(pm),
    .mac_status_reg_in(mac), .mac_copy_enable_in(cp),
    .dma_wdt_priority_reg_in(p_dw), .ether_frt_priority_reg_in(p_ef),
    .pin_priority_reg_in(p_pin), .pulse_serial_priority_reg_in(16'h0000),
    .serial2_priority_reg_in(16'h0000), .vector_regs_in(vregs),
    .vector_base_reg_in(base), .irq_req_out(req), .irq_level_out(lvl),
    .irq_vector_out(vec), .vec_table_addr_out(addr), .irq_src_out(),
    .encoded_mode_out(encm), .ext_vec_range_err_out(err),
    .ether_dma_request_out(eth));
  imvp_core_model imvp_core_model_inst (.clk_in(clk), .rst_in(rst),
    .req_in(req), .vec_in(vec), .taken_out(taken), .vec_out(cvec));
  task automatic report(input logic [45:0] got, input logic [45:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask : report
  // Address and core view follow from the expected vector
  task automatic check_irq(input logic r, input logic [4:0] l,
      input logic [6:0] v);
    report({req, lvl, vec, addr, taken}, {r, l, v,
      r ? base + {23'h000000, v, 2'b00} : 32'h0000_0000, r});
  endtask : check_irq
  task automatic check_flag(input logic g, input logic e);
    report({45'h0, g}, {45'h0, e});
  endtask : check_flag
  // Pins need five edges, so six covers every path
  task automatic settle();
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task automatic test_done();
    $display("checks=%0d failures=%0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Hang guard at 20000 cycles, far above the length of the test
  initial begin
    #100000;
    failures++;
    test_done();
  end
  // Vector slots 0..16 only; the reserved slot has no entry
  initial begin
    for (int i = 0; i < N_VREG; i++) vregs[i] = 16'h0000;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    p_pin <= 16'h1234;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      pins_n <= ~(4'h1 << i);
      settle();
      check_irq(1'b1, 5'(i + 1), 7'h40 + 7'(i));
    end
    @(posedge clk);
    {p_pin, pins_n} <= {16'h0000, 4'h0};
    settle();
    check_irq(1'b0, 5'h00, 7'h00);
    $display("lines test done");
    @(posedge clk);
    {p_pin, mode, pins_n} <= {16'hFFFF, 1'b1, 4'hA};
    settle();
    check_irq(1'b1, 5'h05, 7'h45);
    check_flag(encm, 1'b1);
    @(posedge clk);
    {fetch, xvec} <= {1'b1, 8'h25};
    settle();
    check_irq(1'b1, 5'h05, 7'h25);
    @(posedge clk);
    xvec <= 8'h90;
    settle();
    check_irq(1'b1, 5'h05, 7'h7F);
    check_flag(err, 1'b1);
    $display("encoded test done");
    @(posedge clk);
    {mode, fetch, pins_n, p_pin} <= {2'b00, 4'hF, 16'h0000};
    {p_dw, wdt, refr} <= {16'h0650, 2'b11};
    {vregs[0], vregs[2]} <= {16'h0031, 16'h3A15};
    settle();
    check_irq(1'b1, 5'h05, 7'h3A);
    @(posedge clk);
    wdt <= 1'b0;
    settle();
    check_irq(1'b1, 5'h05, 7'h15);
    @(posedge clk);
    dma <= 2'h3;
    settle();
    check_irq(1'b1, 5'h06, 7'h31);
    $display("watchdog test done");
    @(posedge clk);
    {dma, refr, p_dw, p_ef} <= {3'h0, 16'h0000, 16'h7700};
    {vregs[3], vregs[4], st} <= {16'h2200, 16'h4400, 19'h00020};
    settle();
    check_flag(eth, 1'b0);
    @(posedge clk);
    {pm, frt} <= {19'h00020, 3'h1};
    settle();
    check_irq(1'b1, 5'h07, 7'h22);
    @(posedge clk);
    {st, pm, mac, cp} <= {19'h00000, 19'h00001, 3'h2, 3'h2};
    settle();
    check_flag(eth, 1'b1);
    @(posedge clk);
    cp <= 3'h0;
    settle();
    check_irq(1'b1, 5'h07, 7'h44);
    $display("ethernet test done");
    @(posedge clk);
    {frt, ubrk, dbg} <= {3'h0, 2'b11};
    settle();
    check_irq(1'b1, 5'h0F, 7'h0C);
    @(posedge clk);
    ubrk <= 1'b0;
    settle();
    check_irq(1'b1, 5'h0F, 7'h0D);
    @(posedge clk);
    nmi <= 1'b1;
    settle();
    check_irq(1'b1, 5'h10, 7'h0B);
    $display("fixed test done");
    test_done();
  end
endmodule : imvp_top_tb
